// [rtl/dcc_cap_cmp_unit.v]
// Dual-array capture/compare unit with four base timers and an AHB-Lite slave
// Function
// - Thirty-two channels; fast prescale advances timers once every sixteen half periods.
// - Four 16-bit timers with reload; one pair per sixteen-channel array.
// - Timer source: fast or slow prescale, or auxiliary timer overflow.
// - First timer of each pair may also count external input rising edges.
// - Each array holds sixteen channels, each assignable to either pair timer.
// - Each channel programmable for capture or one compare mode.
// - One pin per channel; channels 24 to 27 never drive output.
// - Capture copies assigned timer into channel on selected pin edge.
// - Every capture raises that channel's own interrupt request.
// - Capture edge per channel: rising, falling, or both.
// - Compare channels match continuously against timer; action per mode.
// - Compare mode 0: interrupt only, many per period, pin untouched.
// - Compare mode 1: pin toggles on every match.
// - Compare mode 2: interrupt only, at most one per period.
// - Compare mode 3: pin set on match, cleared on overflow, once per period.
// - Double mode: channel pair shares lower pin, toggles on either match.
//
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`include "dcc_defines.vh"

module dcc_cap_cmp_unit (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	output reg irq,
	input wire aux_ovf,
	input wire [1:0] ext_count_in,
	input wire [31:0] chan_pin_in,
	output reg [31:0] chan_pin_out,
	output reg [31:0] chan_pin_oe
);

	////////////////////////////////////////////////////////////////////////
	// Bus slave: one wait state so read data comes straight from a flop

	reg busy_reg;
	reg wr_reg;
	reg [11:0] addr_reg;
	wire take = hsel & htrans[1] & hready;
	wire [7:0] aw = addr_reg[9:2];
	wire mapped = (addr_reg[11:10] == 2'h0);
	wire wr_go = busy_reg & wr_reg & mapped;
	wire rd_go = busy_reg & ~wr_reg & mapped;

	// Decode of a write to one word, used by every register
	function wr_hit;
		input go;
		input [7:0] idx;
		input [7:0] target;
		begin
			wr_hit = go & (idx == target);
		end
	endfunction

	// Address phase capture and wait state
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_reg <= 1'b0;
			wr_reg <= 1'b0;
			addr_reg <= 12'h000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
			if (busy_reg) begin
				busy_reg <= 1'b0;
				hreadyout <= 1'b1;
			end else if (take) begin
				busy_reg <= 1'b1;
				wr_reg <= hwrite;
				addr_reg <= haddr[11:0];
				hreadyout <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers and edge detection

	reg [31:0] pin_s1_reg;
	reg [31:0] pin_s2_reg;
	reg [31:0] pin_s3_reg;
	reg [1:0] ext_s1_reg;
	reg [1:0] ext_s2_reg;
	reg [1:0] ext_s3_reg;

	// Edge detectors look only at the second and third stages
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1_reg <= `DCC_RST32;
			pin_s2_reg <= `DCC_RST32;
			pin_s3_reg <= `DCC_RST32;
			ext_s1_reg <= 2'h0;
			ext_s2_reg <= 2'h0;
			ext_s3_reg <= 2'h0;
		end else begin
			pin_s1_reg <= chan_pin_in;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			ext_s1_reg <= ext_count_in;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
		end
	end

	wire [31:0] pin_rise = pin_s2_reg & ~pin_s3_reg;
	wire [31:0] pin_fall = ~pin_s2_reg & pin_s3_reg;
	wire [1:0] ext_rise = ext_s2_reg & ~ext_s3_reg;

	////////////////////////////////////////////////////////////////////////
	// Prescaler: fast tick is the finest resolution, slow tick a divided one

	reg [5:0] pre_reg;
	wire fast_tick = (pre_reg[2:0] == (`DCC_RES_CYCLES - 1));
	wire slow_tick = (pre_reg == (`DCC_SLOW_DIV - 1));

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pre_reg <= 6'h00;
		else
			pre_reg <= pre_reg + 6'h01;
	end

	////////////////////////////////////////////////////////////////////////
	// Timer control register

	reg [`DCC_TCTL_W-1:0] tctl_reg;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			tctl_reg <= 16'h0000;
		else if (wr_hit(wr_go, aw, `DCC_IDX_TCTL))
			tctl_reg <= hwdata[15:0];
	end

	////////////////////////////////////////////////////////////////////////
	// Base timers; 0,1 serve the first array and 2,3 the second

	wire [63:0] tmr_all;
	wire [63:0] rld_all;
	wire [3:0] tick_d_all;
	wire [3:0] ovf_d_all;

	genvar t;
	generate
		for (t = 0; t < `DCC_NTIMER; t = t + 1) begin : g_tmr
			reg [15:0] val_reg;
			reg [15:0] rld_reg;
			reg tick_d_reg;
			reg ovf_d_reg;
			wire [1:0] src = tctl_reg[t*4+1:t*4];
			wire run = tctl_reg[t*4+`DCC_TCTL_RUN];
			localparam [31:0] TIDX = `DCC_IDX_TMR0 + t;
			localparam [31:0] RIDX = `DCC_IDX_RLD0 + t;
			wire ext_ok = ((t % 2) == 0) ? ext_rise[t/2] : 1'b0;
			reg src_tick;
			wire tick;
			wire ovf;

			// external count on first timer of each pair only
			always @* begin
				case (src)
					`DCC_SRC_FAST: src_tick = fast_tick;
					`DCC_SRC_SLOW: src_tick = slow_tick;
					`DCC_SRC_AUX: src_tick = aux_ovf;
					`DCC_SRC_EXT: src_tick = ext_ok;
					default: src_tick = 1'b0;
				endcase
			end

			assign tick = run & src_tick;
			assign ovf = tick & (val_reg == `DCC_TMR_MAX);

			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					val_reg <= `DCC_RST16;
					rld_reg <= `DCC_RST16;
					tick_d_reg <= 1'b0;
					ovf_d_reg <= 1'b0;
				end else begin
					tick_d_reg <= tick;
					ovf_d_reg <= ovf;
					if (ovf)
						val_reg <= rld_reg;
					else if (tick)
						val_reg <= val_reg + 16'h0001;
					else if (wr_hit(wr_go, aw, TIDX[7:0]))
						val_reg <= hwdata[15:0];
					if (wr_hit(wr_go, aw, RIDX[7:0]))
						rld_reg <= hwdata[15:0];
				end
			end

			assign tmr_all[t*16+15:t*16] = val_reg;
			assign rld_all[t*16+15:t*16] = rld_reg;
			assign tick_d_all[t] = tick_d_reg;
			assign ovf_d_all[t] = ovf_d_reg;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Channels

	wire [511:0] val_all;
	wire [191:0] ctl_all;
	wire [31:0] ev;
	wire [31:0] dbl_hit;
	wire [31:0] pin_vec;
	wire [31:0] oe_vec;

	genvar i;
	generate
		for (i = 0; i < `DCC_NCHAN; i = i + 1) begin : g_ch
			localparam integer ARR = i / `DCC_NARRAY_CHAN;
			localparam integer LOWER = ((i % `DCC_NARRAY_CHAN) < 8) ? 1 : 0;
			localparam integer PART = (LOWER == 1) ? i + 8 : i - 8;
			// no output on channels 24 to 27
			localparam integer HAS_OUT = ((i >= 24) && (i <= 27)) ? 0 : 1;
			localparam [31:0] VIDX = `DCC_IDX_VAL0 + i;
			localparam [31:0] CIDX = `DCC_IDX_CTL0 + i;
			reg [15:0] val_reg;
			reg [`DCC_CTL_W-1:0] ctl_reg;
			reg armed_reg;
			reg pin_reg;
			reg oe_reg;
			wire [2:0] mode = ctl_reg[`DCC_CTL_MODE_HI:0];
			wire tsel = ctl_reg[`DCC_CTL_TSEL];
			wire [15:0] tv = tsel ? tmr_all[(2*ARR+1)*16+15:(2*ARR+1)*16]
				: tmr_all[2*ARR*16+15:2*ARR*16];
			wire tk = tsel ? tick_d_all[2*ARR+1] : tick_d_all[2*ARR];
			wire ov = tsel ? ovf_d_all[2*ARR+1] : ovf_d_all[2*ARR];
			wire is_cmp = mode[2];
			// continuous match against new timer value
			wire hit = tk & (tv == val_reg);
			wire cap_ev = (mode == `DCC_MODE_CAP) &
				((ctl_reg[`DCC_CTL_RISE] & pin_rise[i]) | (ctl_reg[`DCC_CTL_FALL] & pin_fall[i]));
			wire once = (mode == `DCC_MODE_CMP2) | (mode == `DCC_MODE_CMP3);
			wire cmp_ev = hit & (is_cmp | (mode == `DCC_MODE_DBL)) & (~once | armed_reg);
			wire pair_hit = (LOWER == 1) ? (dbl_hit[i] | dbl_hit[PART]) : 1'b0;

			assign dbl_hit[i] = hit & (mode == `DCC_MODE_DBL);
			assign ev[i] = cap_ev | cmp_ev;

			// mode and capture value; capture beats a bus write
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					val_reg <= `DCC_RST16;
					ctl_reg <= 6'h00;
				end else begin
					if (cap_ev)
						val_reg <= tv;
					else if (wr_hit(wr_go, aw, VIDX[7:0]))
						val_reg <= hwdata[15:0];
					if (wr_hit(wr_go, aw, CIDX[7:0]))
						ctl_reg <= hwdata[`DCC_CTL_W-1:0];
				end
			end

			// one event per period, re-armed by overflow
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn)
					armed_reg <= 1'b1;
				else if (once & hit & armed_reg)
					armed_reg <= 1'b0;
				else if (ov)
					armed_reg <= 1'b1;
			end

			// Pin driver; an armed match in the overflow cycle still sets the pin
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pin_reg <= 1'b0;
					oe_reg <= 1'b0;
				end else if (HAS_OUT == 0) begin
					pin_reg <= 1'b0;
					oe_reg <= 1'b0;
				end else begin
					oe_reg <= (mode == `DCC_MODE_CMP1) | (mode == `DCC_MODE_CMP3) |
						((mode == `DCC_MODE_DBL) & (LOWER == 1));
					case (mode)
						`DCC_MODE_CMP1: if (hit) pin_reg <= ~pin_reg;
						// set on match, clear on overflow
						`DCC_MODE_CMP3: begin
							if (hit & armed_reg)
								pin_reg <= 1'b1;
							else if (ov)
								pin_reg <= 1'b0;
						end
						// shared pin toggles on either match
						`DCC_MODE_DBL: if (pair_hit) pin_reg <= ~pin_reg;
						default: pin_reg <= pin_reg;
					endcase
				end
			end

			assign val_all[i*16+15:i*16] = val_reg;
			assign ctl_all[i*6+5:i*6] = ctl_reg;
			assign pin_vec[i] = pin_reg;
			assign oe_vec[i] = oe_reg;
		end
	endgenerate

	// Collect pin flops into the output flops
	integer k;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chan_pin_out <= `DCC_RST32;
			chan_pin_oe <= `DCC_RST32;
		end else begin
			for (k = 0; k < `DCC_NCHAN; k = k + 1) begin
				chan_pin_out[k] <= g_pin_val(k);
				chan_pin_oe[k] <= g_oe_val(k);
			end
		end
	end

	function g_pin_val;
		input integer n;
		begin
			g_pin_val = pin_vec[n];
		end
	endfunction

	function g_oe_val;
		input integer n;
		begin
			g_oe_val = oe_vec[n];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Interrupt status, mask and level output

	reg [31:0] stat_reg;
	reg [31:0] mask_reg;
	// A new event in the clearing read cycle survives the clear
	wire [31:0] stat_next = (rd_go & (aw == `DCC_IDX_STAT)) ? ev : (stat_reg | ev);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_reg <= `DCC_RST32;
			mask_reg <= `DCC_RST32;
			irq <= 1'b0;
		end else begin
			stat_reg <= stat_next;
			if (wr_hit(wr_go, aw, `DCC_IDX_MASK))
				mask_reg <= hwdata;
			irq <= |(stat_next & (wr_hit(wr_go, aw, `DCC_IDX_MASK) ? hwdata : mask_reg));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read multiplexer, registered in the wait state

	reg [31:0] rd_mux;
	always @* begin
		rd_mux = `DCC_RST32;
		if (aw < `DCC_IDX_CTL0)
			rd_mux = {16'h0000, val_all[aw[4:0]*16 +: 16]};
		else if (aw < `DCC_IDX_TMR0)
			rd_mux = {26'h0, ctl_all[aw[4:0]*6 +: 6]};
		else if (aw < `DCC_IDX_RLD0)
			rd_mux = {16'h0000, tmr_all[aw[1:0]*16 +: 16]};
		else if (aw < `DCC_IDX_TCTL)
			rd_mux = {16'h0000, rld_all[aw[1:0]*16 +: 16]};
		else if (aw == `DCC_IDX_TCTL)
			rd_mux = {16'h0000, tctl_reg};
		else if (aw == `DCC_IDX_STAT)
			rd_mux = stat_reg;
		else if (aw == `DCC_IDX_MASK)
			rd_mux = mask_reg;
	end

	// Unmapped reads return zero
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= `DCC_RST32;
		else if (rd_go)
			hrdata <= rd_mux;
		else if (busy_reg)
			hrdata <= `DCC_RST32;
	end

endmodule // dcc_cap_cmp_unit

// [rtl/dcc_defines.vh]
// Constants of the dual-array capture/compare unit: map, fields, timing
`ifndef DCC_DEFINES_VH
`define DCC_DEFINES_VH

// Timing: finest resolution is sixteen clock half periods
`define DCC_CLK_PERIOD_PS 25000
`define DCC_HALF_PERIOD_PS 12500
`define DCC_RES_HALF_PERIODS 16
`define DCC_RES_CYCLES ((`DCC_RES_HALF_PERIODS * `DCC_HALF_PERIOD_PS) / `DCC_CLK_PERIOD_PS)
`define DCC_SLOW_DIV 64

// Geometry
`define DCC_NCHAN 32
`define DCC_NARRAY_CHAN 16
`define DCC_NTIMER 4
`define DCC_TW 16

// Word index map (byte address = index * 4)
`define DCC_IDX_VAL0 8'h00
`define DCC_IDX_CTL0 8'h20
`define DCC_IDX_TMR0 8'h40
`define DCC_IDX_RLD0 8'h44
`define DCC_IDX_TCTL 8'h48
`define DCC_IDX_STAT 8'h49
`define DCC_IDX_MASK 8'h4A

// Channel control fields
`define DCC_CTL_W 6
`define DCC_CTL_MODE_HI 2
`define DCC_CTL_TSEL 3
`define DCC_CTL_RISE 4
`define DCC_CTL_FALL 5

// Channel modes
`define DCC_MODE_OFF 3'h0
`define DCC_MODE_CAP 3'h1
`define DCC_MODE_DBL 3'h2
`define DCC_MODE_CMP0 3'h4
`define DCC_MODE_CMP1 3'h5
`define DCC_MODE_CMP2 3'h6
`define DCC_MODE_CMP3 3'h7

// Timer control: four bits per timer, source in [1:0], run in [2]
`define DCC_TCTL_W 16
`define DCC_SRC_FAST 2'h0
`define DCC_SRC_SLOW 2'h1
`define DCC_SRC_AUX 2'h2
`define DCC_SRC_EXT 2'h3
`define DCC_TCTL_RUN 2

// Timer maximum and reset values
`define DCC_TMR_MAX 16'hFFFF
`define DCC_RST16 16'h0000
`define DCC_RST32 32'h00000000

`endif

// [sim/dcc_pin_model.sv]
// Port pin model facing the capture/compare unit
module dcc_pin_model (
	input wire [31:0] pin_drv,
	input wire [31:0] chan_pin_out,
	input wire [31:0] chan_pin_oe,
	output wire [31:0] chan_pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// one pin per channel
	// A driving channel owns its pin, otherwise the outside level shows
	assign chan_pin_in = (chan_pin_oe & chan_pin_out) | (~chan_pin_oe & pin_drv);
endmodule // dcc_pin_model

// [sim/dcc_cap_cmp_unit_sva.sv]
// Assertion checker on the capture/compare unit ports
module dcc_cap_cmp_unit_sva (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	input wire irq,
	input wire [31:0] chan_pin_out,
	input wire [31:0] chan_pin_oe
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Transfer accepted while the slave is idle
	wire take = hsel && htrans[1] && hreadyout;
	////////////////////////////////
	a_take_wait: assert property (take |=> !hreadyout)
		else $error("no wait state");
	a_wait_once: assert property (!hreadyout |=> hreadyout)
		else $error("wait too long");
	a_resp_okay: assert property (hresp == 1'h0)
		else $error("bad response");
	a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
		else $error("read data moved");
	a_unmap_zero: assert property (
		take && !hwrite && haddr[11:10] != 2'h0 |-> ##2 hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_input_only: assert property (chan_pin_oe[27:24] == 4'h0)
		else $error("input-only pin driven");
	// Enables move two edges after a control write ends its wait state
	a_oe_by_bus: assert property (
		$changed(chan_pin_oe) |-> !$past(hreadyout, 3))
		else $error("enable moved without bus");
	// Interrupt falls only as a status read or mask write completes
	a_irq_clear: assert property (
		$fell(irq) |-> !$past(hreadyout) || !$past(hreadyout, 2))
		else $error("irq fell without bus");
	c_irq: cover property ($rose(irq));
	c_pin: cover property ($changed(chan_pin_out));
	c_write: cover property (take && hwrite);
endmodule // dcc_cap_cmp_unit_sva

bind dcc_cap_cmp_unit dcc_cap_cmp_unit_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hrdata, .hreadyout, .hresp, .irq, .chan_pin_out, .chan_pin_oe);

// [sim/dual_array_capture_compare_tb.sv]
// Self-checking bench of the capture/compare unit
`include "dcc_defines.vh"
module dual_array_capture_compare_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'h0;
	logic hresetn = 1'h0;
	logic hsel = 1'h0;
	logic hwrite = 1'h0;
	logic aux_ovf = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [1:0] ext = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] drv = 32'h0;
	logic [31:0] rv;
	wire [31:0] hrdata, pout, poe, pin;
	wire hreadyout, hresp, irq;
	int err_count = 0;
	int checks = 0;
	int cyc = 0;

	// 40 MHz clock
	always #12.5 hclk = ~hclk;

	dcc_cap_cmp_unit dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .aux_ovf,
		.ext_count_in(ext), .chan_pin_in(pin), .chan_pin_out(pout), .chan_pin_oe(poe));
	dcc_pin_model pm (.pin_drv(drv), .chan_pin_out(pout), .chan_pin_oe(poe),
		.chan_pin_in(pin));

	////////////////////////////////
	task automatic finish_test();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// One AHB-Lite single word; waits as long as the slave stalls
	task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0, idx, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		rv = hrdata;
	endtask

	task automatic wr(input logic [9:0] i, input logic [31:0] d);
		bus(1'h1, i, d);
	endtask

	task automatic rd(input logic [9:0] i);
		bus(1'h0, i, 32'h0);
	endtask

	task automatic stat(input logic [31:0] m, input logic [31:0] e);
		rd(`DCC_IDX_STAT);
		chk(rv & m, e);
	endtask

	// Count input pulse, long enough to pass the input synchroniser
	task automatic pulse(input int b);
		ext[b] <= 1'h1;
		tick(4);
		ext[b] <= 1'h0;
		tick(12);
	endtask

	////////////////////////////////
	task automatic t_bus();
		rd(`DCC_IDX_TMR0);
		chk(rv, 32'h0);
		wr(`DCC_IDX_RLD0 + 8'h3, 32'hABCD1234);
		rd(`DCC_IDX_RLD0 + 8'h3);
		chk(rv, 32'h1234);
		wr(10'h100, 32'hFFFF);
		rd(10'h100);
		chk(rv, 32'h0);
	endtask

	task automatic t_capture();
		wr(`DCC_IDX_TMR0, 32'h1234);
		wr(`DCC_IDX_TMR0 + 8'h1, 32'h5678);
		wr(`DCC_IDX_CTL0, 32'h11);
		wr(`DCC_IDX_CTL0 + 8'h1, 32'h29);
		wr(`DCC_IDX_CTL0 + 8'h2, 32'h31);
		wr(`DCC_IDX_MASK, 32'h1);
		drv <= 32'h7;
		tick(8);
		chk({31'h0, irq}, 32'h1);
		stat(32'hFFFFFFFF, 32'h5);
		chk({31'h0, irq}, 32'h0);
		wr(`DCC_IDX_TMR0, 32'h42);
		drv <= 32'h0;
		tick(8);
		stat(32'hFFFFFFFF, 32'h6);
		rd(`DCC_IDX_VAL0);
		chk(rv, 32'h1234);
		rd(`DCC_IDX_VAL0 + 8'h1);
		chk(rv, 32'h5678);
		rd(`DCC_IDX_VAL0 + 8'h2);
		chk(rv, 32'h42);
		wr(`DCC_IDX_MASK, 32'h0);
	endtask

	// Channels 3 and 11 doubled, 4 to 7 in modes 0 to 3, timer 0 on count input
	task automatic t_compare();
		wr(`DCC_IDX_RLD0, 32'hFFFD);
		wr(`DCC_IDX_TMR0, 32'hFFFD);
		for (int i = 3; i < 8; i++) begin
			wr(`DCC_IDX_VAL0 + i[7:0], 32'hFFFE);
			wr(`DCC_IDX_CTL0 + i[7:0], {29'h0, (i < 4) ? 3'h2 : i[2:0]});
		end
		wr(`DCC_IDX_VAL0 + 8'hB, 32'hFFFF);
		wr(`DCC_IDX_CTL0 + 8'hB, 32'h2);
		wr(`DCC_IDX_CTL0 + 8'h18, 32'h5);
		wr(`DCC_IDX_TCTL, 32'h7);
		chk(poe & 32'h010008A8, 32'hA8);
		pulse(0);
		chk(pout & 32'hB8, 32'hA8);
		stat(32'hFF8, 32'hF8);
		pulse(0);
		chk(pout & 32'hB8, 32'hA0);
		stat(32'hFF8, 32'h800);
		pulse(0);
		chk(pout & 32'hB8, 32'h20);
		rd(`DCC_IDX_TMR0);
		chk(rv, 32'hFFFD);
		pulse(0);
		chk(pout & 32'hB8, 32'h88);
		stat(32'hFF8, 32'hF8);
		wr(`DCC_IDX_TMR0, 32'hFFFD);
		pulse(0);
		chk(pout & 32'hB8, 32'hA0);
		stat(32'h50, 32'h10);
		wr(`DCC_IDX_TCTL, 32'h0);
	endtask

	// Second array: timer 2 on auxiliary overflow, timer 3 on fast prescale
	task automatic t_arrayb();
		wr(`DCC_IDX_TMR0 + 8'h2, 32'h0);
		wr(`DCC_IDX_TMR0 + 8'h3, 32'h0);
		wr(`DCC_IDX_VAL0 + 8'h10, 32'h5);
		wr(`DCC_IDX_CTL0 + 8'h10, 32'hC);
		wr(`DCC_IDX_CTL0 + 8'h11, 32'h11);
		rd(`DCC_IDX_STAT);
		wr(`DCC_IDX_TCTL, 32'h4600);
		repeat (3) begin
			aux_ovf <= 1'h1;
			tick(1);
			aux_ovf <= 1'h0;
			tick(2);
		end
		drv[17] <= 1'h1;
		tick(100);
		chk({31'h0, irq}, 32'h0);
		stat(32'h30000, 32'h30000);
		rd(`DCC_IDX_VAL0 + 8'h11);
		chk(rv, 32'h3);
		wr(`DCC_IDX_TCTL, 32'h700);
		pulse(1);
		rd(`DCC_IDX_TMR0 + 8'h2);
		chk(rv, 32'h4);
		// Timer 1 on slow prescale for 204 edges: three or four ticks, by phase
		wr(`DCC_IDX_TMR0 + 8'h1, 32'h0);
		wr(`DCC_IDX_TCTL, 32'h50);
		tick(200);
		wr(`DCC_IDX_TCTL, 32'h0);
		rd(`DCC_IDX_TMR0 + 8'h1);
		chk({31'h0, (rv == 32'h3) || (rv == 32'h4)}, 32'h1);
	endtask

	// Hang guard
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 4000) begin
			err_count++;
			finish_test();
		end
	end

	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'h1;
		t_bus();
		t_capture();
		t_compare();
		t_arrayb();
		finish_test();
	end
endmodule // dual_array_capture_compare_tb
